// file: src/cdc_datapath_control.sv
// Purpose: register bank and source routing of the codec audio path
// Assumes: all streams and the register port run on sys_clk
// Notes:   stereo words hold left in the upper half, right in the lower
//
// Function
// [R1] eight polarity bits reset ones, zero inverts
// [R2] polarity bits map DAC1L through DAC4R
// [R3] adc high-pass active, bit 4 bypasses
// [R4] adc runs 128fs, 64fs at low ratios
// [R5] bit 3 halves adc oversampling, resets 0
// [R6] software sets halve bit for high rates
// [R7] bits 0 and 1 mute left, right
// [R8] bit 2 mutes both adc channels
// [R9] any data input pin feeds any DAC
// [R10] DAC1 input also feeds secondary, spdif transmitters
// [R11] DACs 2 to 4 primary data only
// [R12] DAC1 source field bits 8:7, reset 11
// [R13] spdif-fed DAC1 may power down others
// [R14] primary transmit source field, reset 01
// [R15] secondary transmit source field, reset 00
// [R16] spdif transmit source bits 1:0, reset 00
// [R17] raw thru bit picks output pin source
// [R18] reserved codes read back, route nothing

`timescale 1ns/1ps
`default_nettype none

module cdc_fifo #(
    parameter int W     = 48,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset,
    // filling side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // draining side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   count_q;
    wire           push;
    wire           pop;
    wire  [AW-1:0] ptr_last;

    assign ptr_last  = AW'(DEPTH - 1);
    assign in_ready  = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == ptr_last) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == ptr_last) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

module cdc_datapath_control
    import cdc_pkg::*;
#(
    parameter int SW    = SAMPLE_W,
    parameter int FDEPH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                               sys_clk,
    input  wire logic                               reset,
    // register port
    input  wire logic                               reg_wr_en,
    input  wire logic [6:0]                         reg_wr_addr,
    input  wire logic [8:0]                         reg_wr_data,
    input  wire logic [6:0]                         reg_rd_addr,
    output logic [8:0]                              reg_rd_data,
    // primary receiver data pins and their routing
    input  wire logic [NUM_DAC-1:0][2*SW-1:0]       din_data,
    input  wire logic [NUM_DAC-1:0]                 din_valid,
    input  wire logic [NUM_DAC-1:0][1:0]            din_route_sel,
    // other sources
    input  wire logic [2*SW-1:0]                    spdif_rx_data,
    input  wire logic                               spdif_rx_valid,
    input  wire logic [2*SW-1:0]                    sec_rx_data,
    input  wire logic                               sec_rx_valid,
    input  wire logic [2*SW-1:0]                    adc_raw_data,
    input  wire logic                               adc_raw_valid,
    output logic [NUM_SRC-1:0]                      src_ready,
    // mode inputs
    input  wire logic [2:0]                         mclk_ratio,
    input  wire logic                               receiver_to_dac_mode,
    // dac outputs
    output logic [NUM_DAC-1:0][2*SW-1:0]            dac_data,
    output logic [NUM_DAC-1:0]                      dac_valid,
    output logic                                    dac_2to4_powerdown,
    // adc outputs
    output logic [2*SW-1:0]                         adc_data,
    output logic                                    adc_valid,
    output logic                                    adc_hpf_bypass,
    output logic [1:0]                              adc_osr,
    // interface transmitters
    output logic [2*SW-1:0]                         primary_tx_data,
    output logic                                    primary_tx_valid,
    output logic [2*SW-1:0]                         secondary_tx_data,
    output logic                                    secondary_tx_valid,
    // spdif transmitter
    output logic [2*SW-1:0]                         spdif_tx_data,
    output logic                                    spdif_tx_valid,
    input  wire logic                               spdif_tx_ready,
    input  wire logic                               spdif_in_mux_bit,
    input  wire logic                               spdif_tx_bit,
    output logic                                    spdif_output_pin
);
    localparam int DW = 2 * SW;

    // control registers
    logic [1:0] dac1_source_field_q;
    logic [1:0] primary_tx_source_field_q;
    logic [1:0] secondary_tx_source_field_q;
    logic [1:0] spdif_tx_source_field_q;
    logic       real_thru_q;
    logic [7:0] polarity_q;
    logic [4:0] adc_ctl_q;
    logic [8:0] rd_data_q;

    // write decode
    wire wr_dac1  = reg_wr_en && (reg_wr_addr == ADDR_DAC1_SRC);
    wire wr_ptx   = reg_wr_en && (reg_wr_addr == ADDR_PTX_SRC);
    wire wr_stx   = reg_wr_en && (reg_wr_addr == ADDR_STX_SRC);
    wire wr_pol   = reg_wr_en && (reg_wr_addr == ADDR_POLARITY);
    wire wr_adc   = reg_wr_en && (reg_wr_addr == ADDR_ADC_CTL);
    wire wr_spdif = reg_wr_en && (reg_wr_addr == ADDR_SPDIF_SRC);
    wire [1:0] wr_hi_field = reg_wr_data[SRC_HI_LSB +: 2];
    wire [1:0] wr_lo_field = reg_wr_data[SRC_LO_LSB +: 2];

    // [R1] [R3] [R5] [R7] [R8] [R12] [R14] [R15] [R16] [R17] reset values
    // [R18] reserved codes are stored as written
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dac1_source_field_q         <= RST_DAC1_SRC;
            primary_tx_source_field_q   <= RST_PTX_SRC;
            secondary_tx_source_field_q <= RST_STX_SRC;
            spdif_tx_source_field_q     <= RST_SPDIF_SRC;
            real_thru_q                 <= 1'b0;
            polarity_q                  <= RST_POLARITY;
            adc_ctl_q                   <= RST_ADC_CTL;
        end else begin
            if (wr_dac1) begin
                dac1_source_field_q <= wr_hi_field;
            end
            if (wr_ptx) begin
                primary_tx_source_field_q <= wr_hi_field;
            end
            if (wr_stx) begin
                secondary_tx_source_field_q <= wr_hi_field;
            end
            if (wr_spdif) begin
                spdif_tx_source_field_q <= wr_lo_field;
                real_thru_q             <= reg_wr_data[REAL_THRU_BIT];
            end
            if (wr_pol) begin
                polarity_q <= reg_wr_data[7:0];
            end
            if (wr_adc) begin
                adc_ctl_q <= reg_wr_data[4:0];
            end
        end
    end

    // readback; unmapped addresses and unused bits read zero
    wire [8:0] rd_hi_dac1  = {dac1_source_field_q, 7'h00};
    wire [8:0] rd_hi_ptx   = {primary_tx_source_field_q, 7'h00};
    wire [8:0] rd_hi_stx   = {secondary_tx_source_field_q, 7'h00};
    wire [8:0] rd_spdif    = {5'h00, real_thru_q, 1'b0,
                              spdif_tx_source_field_q};
    wire [8:0] rd_word =
        (reg_rd_addr == ADDR_DAC1_SRC)  ? rd_hi_dac1 :
        (reg_rd_addr == ADDR_PTX_SRC)   ? rd_hi_ptx :
        (reg_rd_addr == ADDR_STX_SRC)   ? rd_hi_stx :
        (reg_rd_addr == ADDR_POLARITY)  ? {1'b0, polarity_q} :
        (reg_rd_addr == ADDR_ADC_CTL)   ? {4'h0, adc_ctl_q} :
        (reg_rd_addr == ADDR_SPDIF_SRC) ? rd_spdif : 9'h000;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= 9'h000;
        end else begin
            rd_data_q <= rd_word;
        end
    end
    assign reg_rd_data = rd_data_q;

    // [R7] [R8] adc channel mutes, the combined bit overrides
    wire mute_left  = adc_ctl_q[ADC_LMUTE_BIT] || adc_ctl_q[ADC_BMUTE_BIT];
    wire mute_right = adc_ctl_q[ADC_RMUTE_BIT] || adc_ctl_q[ADC_BMUTE_BIT];
    wire [SW-1:0] adc_left  = mute_left  ? '0 : adc_raw_data[DW-1:SW];
    wire [SW-1:0] adc_right = mute_right ? '0 : adc_raw_data[SW-1:0];

    logic [DW-1:0] adc_q;
    logic          adc_valid_q;
    logic [1:0]    adc_osr_q;

    // [R4] base rate from ratio; [R5] halve bit drops one step
    wire low_ratio = (mclk_ratio == RATIO_128FS) ||
                     (mclk_ratio == RATIO_192FS);
    wire halve     = adc_ctl_q[ADC_OSR_BIT];
    wire [1:0] osr_d = low_ratio ? (halve ? OSR_32FS : OSR_64FS)
                                 : (halve ? OSR_64FS : OSR_128FS);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            adc_q       <= '0;
            adc_valid_q <= 1'b0;
            adc_osr_q   <= OSR_128FS;
        end else begin
            adc_q       <= {adc_left, adc_right};
            adc_valid_q <= adc_raw_valid;
            adc_osr_q   <= osr_d;
        end
    end
    assign adc_data  = adc_q;
    assign adc_valid = adc_valid_q;
    assign adc_osr   = adc_osr_q;

    // [R3] filter stays in unless bypass bit is set
    assign adc_hpf_bypass = adc_ctl_q[ADC_HPF_BIT];

    // [R10] data routed to DAC1 is the primary source for the secondary and spdif transmitters
    wire [1:0]    pri_pin = din_route_sel[0];
    wire [DW-1:0] src_data [NUM_SRC];
    wire          src_valid [NUM_SRC];
    assign src_data[SRC_SPDIF_RX]  = spdif_rx_data;
    assign src_valid[SRC_SPDIF_RX] = spdif_rx_valid;
    assign src_data[SRC_ADC]       = adc_q;
    assign src_valid[SRC_ADC]      = adc_valid_q;
    assign src_data[SRC_SEC_RX]    = sec_rx_data;
    assign src_valid[SRC_SEC_RX]   = sec_rx_valid;
    assign src_data[SRC_PRI_RX]    = din_data[pri_pin];
    assign src_valid[SRC_PRI_RX]   = din_valid[pri_pin];

    // [R12] [R18] DAC1 selection; the adc code is reserved here
    wire dac1_legal = (dac1_source_field_q != SRC_ADC);
    wire [DW-1:0] dac1_src = dac1_legal ? src_data[dac1_source_field_q]
                                        : '0;
    wire dac1_src_v = dac1_legal && src_valid[dac1_source_field_q];

    // [R13] other DACs may power down when DAC1 takes spdif data
    assign dac_2to4_powerdown = receiver_to_dac_mode &&
                                (dac1_source_field_q == SRC_SPDIF_RX);

    logic [NUM_DAC-1:0][DW-1:0] dac_q;
    logic [NUM_DAC-1:0]         dac_valid_q;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DAC; gi++) begin : g_dac
            // [R9] [R11] DACs 2 to 4 see only their routed pin
            wire [DW-1:0] pick = (gi == 0) ? dac1_src
                                           : din_data[din_route_sel[gi]];
            wire          pick_v = (gi == 0) ? dac1_src_v
                                             : din_valid[din_route_sel[gi]];
            wire [SW-1:0] lft = pick[DW-1:SW];
            wire [SW-1:0] rgt = pick[SW-1:0];
            wire [SW-1:0] one = {{(SW-1){1'b0}}, 1'b1};
            // [R1] [R2] negate when the bit is clear; full scale wraps
            wire [SW-1:0] lft_o = polarity_q[2*gi]   ? lft : (~lft) + one;
            wire [SW-1:0] rgt_o = polarity_q[2*gi+1] ? rgt : (~rgt) + one;

            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    dac_q[gi]       <= '0;
                    dac_valid_q[gi] <= 1'b0;
                end else begin
                    dac_q[gi]       <= {lft_o, rgt_o};
                    dac_valid_q[gi] <= pick_v;
                end
            end
        end
    endgenerate
    assign dac_data  = dac_q;
    assign dac_valid = dac_valid_q;

    // [R14] [R18] primary transmit; code 11 reserved
    wire ptx_legal = (primary_tx_source_field_q != SRC_PRI_RX);
    wire [DW-1:0] ptx_d = ptx_legal ? src_data[primary_tx_source_field_q]
                                    : '0;
    wire ptx_v = ptx_legal && src_valid[primary_tx_source_field_q];

    // [R15] [R18] secondary transmit; code 10 reserved
    wire stx_legal = (secondary_tx_source_field_q != SRC_SEC_RX);
    wire [DW-1:0] stx_d = stx_legal ? src_data[secondary_tx_source_field_q]
                                    : '0;
    wire stx_v = stx_legal && src_valid[secondary_tx_source_field_q];

    logic [DW-1:0] ptx_q;
    logic          ptx_valid_q;
    logic [DW-1:0] stx_q;
    logic          stx_valid_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ptx_q       <= '0;
            ptx_valid_q <= 1'b0;
            stx_q       <= '0;
            stx_valid_q <= 1'b0;
        end else begin
            ptx_q       <= ptx_d;
            ptx_valid_q <= ptx_v;
            stx_q       <= stx_d;
            stx_valid_q <= stx_v;
        end
    end
    assign primary_tx_data    = ptx_q;
    assign primary_tx_valid   = ptx_valid_q;
    assign secondary_tx_data  = stx_q;
    assign secondary_tx_valid = stx_valid_q;

    // [R16] spdif transmit source through a buffer; ready goes only
    // to the selected source so a stalled transmitter holds it back
    wire fifo_in_ready;
    assign src_ready = NUM_SRC'({{(NUM_SRC-1){1'b0}}, fifo_in_ready}
                                << spdif_tx_source_field_q);

    cdc_fifo #(
        .W     (DW),
        .DEPTH (FDEPH)
    ) u_spdif_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_data   (src_data[spdif_tx_source_field_q]),
        .in_valid  (src_valid[spdif_tx_source_field_q]),
        .in_ready  (fifo_in_ready),
        .out_data  (spdif_tx_data),
        .out_valid (spdif_tx_valid),
        .out_ready (spdif_tx_ready)
    );

    // [R17] raw thru bypasses the transmitter entirely
    assign spdif_output_pin = real_thru_q ? spdif_in_mux_bit : spdif_tx_bit;

endmodule

`default_nettype wire

// file: pkg/cdc_pkg.sv
// Purpose: constants shared by the codec datapath control block
// Assumes: 9-bit control words, 7-bit register addresses
// Notes:   source codes index one common source table

package cdc_pkg;

    // register addresses
    localparam logic [6:0] ADDR_DAC1_SRC   = 7'h0C;
    localparam logic [6:0] ADDR_PTX_SRC    = 7'h0D;
    localparam logic [6:0] ADDR_STX_SRC    = 7'h0E;
    localparam logic [6:0] ADDR_POLARITY   = 7'h12;
    localparam logic [6:0] ADDR_ADC_CTL    = 7'h1D;
    localparam logic [6:0] ADDR_SPDIF_SRC  = 7'h1E;

    // field positions
    localparam int SRC_HI_LSB     = 7;
    localparam int SRC_LO_LSB     = 0;
    localparam int ADC_LMUTE_BIT  = 0;
    localparam int ADC_RMUTE_BIT  = 1;
    localparam int ADC_BMUTE_BIT  = 2;
    localparam int ADC_OSR_BIT    = 3;
    localparam int ADC_HPF_BIT    = 4;
    localparam int REAL_THRU_BIT  = 3;

    // reset values
    localparam logic [1:0] RST_DAC1_SRC   = 2'h3;
    localparam logic [1:0] RST_PTX_SRC    = 2'h1;
    localparam logic [1:0] RST_STX_SRC    = 2'h0;
    localparam logic [1:0] RST_SPDIF_SRC  = 2'h0;
    localparam logic [7:0] RST_POLARITY   = 8'hFF;
    localparam logic [4:0] RST_ADC_CTL    = 5'h00;

    // common source codes
    localparam logic [1:0] SRC_SPDIF_RX   = 2'h0;
    localparam logic [1:0] SRC_ADC        = 2'h1;
    localparam logic [1:0] SRC_SEC_RX     = 2'h2;
    localparam logic [1:0] SRC_PRI_RX     = 2'h3;
    localparam int         NUM_SRC        = 4;

    // master clock ratio codes
    localparam logic [2:0] RATIO_128FS    = 3'h0;
    localparam logic [2:0] RATIO_192FS    = 3'h1;

    // adc oversampling rate codes
    localparam logic [1:0] OSR_128FS      = 2'h0;
    localparam logic [1:0] OSR_64FS       = 2'h1;
    localparam logic [1:0] OSR_32FS       = 2'h2;

    // data path
    localparam int SAMPLE_W    = 24;
    localparam int NUM_DAC     = 4;
    localparam int FIFO_DEPTH  = 32;

endpackage

// file: tb/cdc_datapath_control_assertions.sv
// Purpose: port-level checks of the codec datapath control
// Assumes: one clock; shadows follow register writes
// Notes:   shadows mirror the polarity, adc, DAC1 source, spdif source and thru fields the block holds
`timescale 1ns/1ps
`default_nettype none
module cdc_datapath_control_assertions
    import cdc_pkg::*;
#(
    parameter int SW = 24
) (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 reset,
    // register port
    input wire logic                 reg_wr_en,
    input wire logic [6:0]           reg_wr_addr,
    input wire logic [8:0]           reg_wr_data,
    input wire logic [6:0]           reg_rd_addr,
    input wire logic [8:0]           reg_rd_data,
    // streams and modes
    input wire logic [3:0][2*SW-1:0] din_data,
    input wire logic [3:0]           din_valid,
    input wire logic [3:0][1:0]      din_route_sel,
    input wire logic                 adc_raw_valid,
    input wire logic                 receiver_to_dac_mode,
    input wire logic                 spdif_in_mux_bit,
    input wire logic                 spdif_tx_bit,
    // outputs
    input wire logic [3:0]           src_ready,
    input wire logic [3:0][2*SW-1:0] dac_data,
    input wire logic [3:0]           dac_valid,
    input wire logic                 dac_2to4_powerdown,
    input wire logic [2*SW-1:0]      adc_data,
    input wire logic                 spdif_output_pin
);
    logic [7:0]    pol_q;
    logic [4:0]    adc_q;
    logic [1:0]    dac1_q;
    logic [1:0]    stx_q;
    logic          thru_q;
    logic [SW-1:0] pin_l;
    logic [SW-1:0] exp_l;
    logic [3:0]    rt_v;

    wire logic wr_pol  = reg_wr_en && reg_wr_addr == ADDR_POLARITY;
    wire logic wr_adc  = reg_wr_en && reg_wr_addr == ADDR_ADC_CTL;
    wire logic wr_dac1 = reg_wr_en && reg_wr_addr == ADDR_DAC1_SRC;
    wire logic wr_spd  = reg_wr_en && reg_wr_addr == ADDR_SPDIF_SRC;

    assign pin_l = din_data[din_route_sel[0]][2*SW-1:SW];
    assign exp_l = pol_q[0] ? pin_l : -pin_l;
    assign rt_v  = {din_valid[din_route_sel[3]], din_valid[din_route_sel[2]],
                    din_valid[din_route_sel[1]], din_valid[din_route_sel[0]]};

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pol_q  <= RST_POLARITY;
            adc_q  <= RST_ADC_CTL;
            dac1_q <= RST_DAC1_SRC;
            stx_q  <= RST_SPDIF_SRC;
            thru_q <= 1'b0;
        end else begin
            if (wr_pol) pol_q <= reg_wr_data[7:0];
            if (wr_adc) adc_q <= reg_wr_data[4:0];
            if (wr_dac1) dac1_q <= reg_wr_data[8:7];
            if (wr_spd) begin
                stx_q  <= reg_wr_data[1:0];
                thru_q <= reg_wr_data[3];
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_pol_read;
        reg_rd_addr == ADDR_POLARITY;
    endsequence
    sequence s_dac1_take;
        dac1_q == SRC_PRI_RX && rt_v[0];
    endsequence

    chk_pol_readback: assert property (
        s_pol_read |=> reg_rd_data == {1'b0, $past(pol_q)})
        else $error("polarity readback differs");
    chk_dac1_polarity: assert property (
        s_dac1_take |=> dac_data[0][2*SW-1:SW] == $past(exp_l))
        else $error("dac1 left polarity wrong");
    chk_route_valid: assert property (
        !dac_2to4_powerdown |=> dac_valid[3:1] == $past(rt_v[3:1]))
        else $error("dac 2 to 4 valid not from routed pin");
    chk_left_mute: assert property (
        (adc_q[0] || adc_q[2]) && adc_raw_valid |=> adc_data[2*SW-1:SW] == '0)
        else $error("left adc not muted");
    chk_right_mute: assert property (
        (adc_q[1] || adc_q[2]) && adc_raw_valid |=> adc_data[SW-1:0] == '0)
        else $error("right adc not muted");
    chk_powerdown_mode: assert property (
        dac_2to4_powerdown == (receiver_to_dac_mode && dac1_q == SRC_SPDIF_RX))
        else $error("powerdown does not follow source and mode");
    chk_ready_select: assert property (
        (src_ready & ~(4'h1 << stx_q)) == 4'h0)
        else $error("unselected source offered ready");
    chk_thru_pin: assert property (
        spdif_output_pin == (thru_q ? spdif_in_mux_bit : spdif_tx_bit))
        else $error("output pin source wrong");
endmodule

bind cdc_datapath_control cdc_datapath_control_assertions #(.SW(SW))
    i_chk (.*);
`default_nettype wire

// file: tb/tb_cdc_datapath_control.sv
// Purpose: self-checking bench for the codec datapath control
// Assumes: inputs change 1 ns after each rising edge
// Notes:   spdif transmit words are matched from a queue
`timescale 1ns/1ps
`default_nettype none
module tb_cdc_datapath_control
    import cdc_pkg::*;
;
    localparam int DW = 2 * SAMPLE_W;
    logic                sys_clk, reset, reg_wr_en, receiver_to_dac_mode;
    logic [6:0]          reg_wr_addr, reg_rd_addr;
    logic [8:0]          reg_wr_data, reg_rd_data;
    logic [3:0][DW-1:0]  din_data, dac_data;
    logic [3:0]          din_valid, dac_valid, src_ready;
    logic [3:0][1:0]     din_route_sel;
    logic [DW-1:0]       spdif_rx_data, sec_rx_data, adc_raw_data, adc_data;
    logic [DW-1:0]       primary_tx_data, secondary_tx_data, spdif_tx_data;
    logic                spdif_rx_valid, sec_rx_valid, adc_raw_valid;
    logic                adc_valid, primary_tx_valid, secondary_tx_valid;
    logic                spdif_tx_valid, spdif_tx_ready, spdif_in_mux_bit;
    logic                spdif_tx_bit, spdif_output_pin, dac_2to4_powerdown;
    logic                adc_hpf_bypass, watch;
    logic [2:0]          mclk_ratio;
    logic [1:0]          adc_osr;
    logic [7:0]          pol;
    logic [DW-1:0]       e [4];
    logic [DW-1:0]       expq [$];
    int                  mismatches, check_count;
    int                  seed = 32'h6DA9;
    logic [6:0] ra [7] = '{7'h0C, 7'h0D, 7'h0E, 7'h12, 7'h1D, 7'h1E, 7'h00};
    logic [8:0] rv [7] = '{9'h180, 9'h080, 0, 9'h0FF, 0, 0, 0};

    cdc_datapath_control #(.SW(SAMPLE_W), .FDEPH(FIFO_DEPTH)) i_dut (.*);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        reg_wr_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        tick();
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [8:0] d);
        reg_rd_addr = a;
        tick();
        check(reg_rd_data, d);
    endtask

    function automatic logic [DW-1:0] rnd();
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        return r[DW-1:0];
    endfunction

    function automatic logic [DW-1:0] pol_fix(input logic [DW-1:0] x,
                                              input logic [1:0] p);
        logic [SAMPLE_W-1:0] l, r;
        l = x[DW-1:SAMPLE_W];
        r = x[SAMPLE_W-1:0];
        return {p[0] ? l : -l, p[1] ? r : -r};
    endfunction

    task automatic new_data;
        spdif_rx_data = rnd();
        sec_rx_data = rnd();
        adc_raw_data = rnd();
        for (int i = 0; i < 4; i++) begin
            din_data[i] = rnd();
            din_route_sel[i] = 2'($random(seed));
        end
    endtask

    always @(posedge sys_clk) begin
        if (watch && spdif_tx_valid && spdif_tx_ready) begin
            check(spdif_tx_data, expq.size() > 0 ? expq.pop_front() : 'x);
        end
    end

    initial begin
        {reg_wr_en, reg_wr_addr, reg_wr_data, reg_rd_addr, din_data,
         din_valid, din_route_sel, spdif_rx_data, spdif_rx_valid, sec_rx_data,
         sec_rx_valid, adc_raw_data, adc_raw_valid, mclk_ratio, watch,
         receiver_to_dac_mode, spdif_in_mux_bit, spdif_tx_bit} = '0;
        reset = 1'b1;
        spdif_tx_ready = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        for (int k = 0; k < 7; k++) begin
            rd(ra[k], rv[k]);
        end
        new_data();
        {din_valid, spdif_rx_valid, sec_rx_valid, adc_raw_valid} = '1;
        receiver_to_dac_mode = 1'b1;
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 3; k++) begin
                wr(ra[k], {c[1:0], 7'h7F});
                rd(ra[k], {c[1:0], 7'h00});
            end
            repeat (3) tick();
            e = '{spdif_rx_data, '0, sec_rx_data, din_data[din_route_sel[0]]};
            check(dac_data[0], e[c]);
            check(dac_valid[0], c != 1);
            e = '{spdif_rx_data, adc_raw_data, sec_rx_data, '0};
            check(primary_tx_data, e[c]);
            check(primary_tx_valid, c != 3);
            e = '{spdif_rx_data, adc_raw_data, '0, din_data[din_route_sel[0]]};
            check(secondary_tx_data, e[c]);
            check(secondary_tx_valid, c != 2);
            check(dac_2to4_powerdown, c == 0);
        end
        for (int v = 0; v < 32; v++) begin
            mclk_ratio = 3'($random(seed));
            wr(7'h1D, 9'(v));
            repeat (3) tick();
            rd(7'h1D, 9'(v));
            check(adc_hpf_bypass, v[4]);
            check(adc_osr, (mclk_ratio < 3'h2) + v[3]);
            check(adc_valid, 1'b1);
            check(adc_data, {v[0] | v[2] ? 24'h0 : adc_raw_data[DW-1:24],
                             v[1] | v[2] ? 24'h0 : adc_raw_data[23:0]});
        end
        for (int t = 0; t < 8; t++) begin
            new_data();
            pol = 8'($random(seed));
            wr(7'h12, {1'b0, pol});
            repeat (3) tick();
            for (int i = 0; i < 4; i++) begin
                e[0] = pol_fix(din_data[din_route_sel[i]], pol[2*i +: 2]);
                check(dac_data[i], e[0]);
            end
        end
        for (int k = 0; k < 8; k++) begin
            {spdif_in_mux_bit, spdif_tx_bit} = 2'(k);
            wr(7'h1E, {5'h0, k[2], 3'h0});
            check(spdif_output_pin, k[2] ? k[1] : k[0]);
            tick();
        end
        {din_valid, spdif_rx_valid, sec_rx_valid, adc_raw_valid} = '0;
        wr(7'h1D, 9'h000);
        repeat (4) tick();
        spdif_tx_ready = 1'b0;
        watch = 1'b1;
        for (int k = 0; k < 40; k++) begin
            spdif_rx_data = rnd();
            spdif_rx_valid = 1'b1;
            if (src_ready[0]) expq.push_back(spdif_rx_data);
            tick();
        end
        spdif_rx_valid = 1'b0;
        check(expq.size(), FIFO_DEPTH);
        check(src_ready, 4'h0);
        for (int k = 0; k < 300 && expq.size() > 0; k++) begin
            spdif_tx_ready = 1'($random(seed));
            tick();
        end
        check(expq.size(), 0);
        spdif_tx_ready = 1'b1;
        for (int c = 1; c < 4; c++) begin
            wr(7'h1E, 9'(c));
            e = '{spdif_rx_data, adc_raw_data, sec_rx_data,
                  din_data[din_route_sel[0]]};
            expq.push_back(e[c]);
            {din_valid, sec_rx_valid, adc_raw_valid} = {4'hF, c == 2, c == 1};
            tick();
            {din_valid, sec_rx_valid, adc_raw_valid} = '0;
            repeat (4) tick();
        end
        check(expq.size(), 0);
        check(spdif_tx_valid, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
